// ==== core/rht_pkg.sv ====
// Shared constants and types for the sensor two-wire bus port.
// Assumes a single 250 MHz clock in both ends.
package rht_pkg;
  localparam int CLK_MHZ      = 250;
  localparam int CYC_PER_US   = CLK_MHZ;
  // Target address pattern, low bit from the strap
  localparam logic [6:0] ADDR_BASE = 7'h40;
  // Command byte codes, bit 0 is don't-care
  localparam logic [7:0] CMD_MASK     = 8'hfe;
  localparam logic [7:0] CMD_READ_TRH = 8'h00;
  localparam logic [7:0] CMD_READ_RH  = 8'h10;
  localparam logic [7:0] CMD_RESET    = 8'h1e;
  localparam logic [7:0] CMD_HEAT_ON  = 8'h04;
  localparam logic [7:0] CMD_HEAT_OFF = 8'h02;
  localparam logic [2:0] CMD_CONV_TOP = 3'h2;
  localparam int CONV_TOP_POS  = 5;
  localparam int HUM_OSR_POS   = 3;
  localparam int TEMP_OSR_POS  = 1;
  // Times in their own units
  localparam int POWER_UP_MS      = 1;
  localparam int SOFT_RESET_MS    = 15;
  localparam int PIN_RESET_MS     = 3;
  localparam int RESET_PULSE_US   = 1;
  localparam int SCL_KHZ          = 400;
  // Conversion times in tenths of a millisecond, OVERSAMPLING_SETTING 0..3
  localparam int HUM_CONV_T10MS  [4] = '{10, 20, 39, 78};
  localparam int TEMP_CONV_T10MS [4] = '{16, 31, 61, 121};
  // Cycle counts
  localparam int T10MS_CYC       = 100 * CYC_PER_US;
  localparam int POWER_UP_CYC    = POWER_UP_MS * 1000 * CYC_PER_US;
  localparam int SOFT_RESET_CYC  = SOFT_RESET_MS * 1000 * CYC_PER_US;
  localparam int PIN_RESET_CYC   = PIN_RESET_MS * 1000 * CYC_PER_US;
  localparam int RESET_PULSE_CYC = RESET_PULSE_US * CYC_PER_US;
  localparam int QTR_CYC         = CLK_MHZ * 1000 / (4 * SCL_KHZ);
  // Checksum over each 16-bit value
  localparam logic [7:0] CRC_POLY = 8'h31;
  localparam logic [7:0] CRC_INIT = 8'hff;

  typedef enum logic [6:0] {
    DS_IDLE    = 7'h01,
    DS_ADDR    = 7'h02,
    DS_ADDR_AK = 7'h04,
    DS_CMD     = 7'h08,
    DS_CMD_AK  = 7'h10,
    DS_TX      = 7'h20,
    DS_TX_AK   = 7'h40
  } rht_dev_state_type;

  typedef enum logic [5:0] {
    HS_IDLE  = 6'h01,
    HS_WAIT  = 6'h02,
    HS_START = 6'h04,
    HS_BIT   = 6'h08,
    HS_STOP  = 6'h10,
    HS_PRST  = 6'h20
  } rht_host_state_type;
endpackage

// ==== core/rht_bus_if.sv ====
// Two-wire bus, strap pin and reset pin between host and sensor.
// Open-drain: an enabled driver with output 0 pulls the wire low.
interface rht_bus_if;
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic address_select_pin;
  logic sensor_rst_n;
  logic scl;
  logic sda;
  assign scl = ~(host_scl_oe & ~host_scl_o);
  assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));
  modport dev (input scl, sda, address_select_pin, sensor_rst_n,
               output dev_sda_o, dev_sda_oe);
  modport host (input scl, sda,
                output host_scl_o, host_scl_oe, host_sda_o, host_sda_oe,
                output address_select_pin, sensor_rst_n);
endinterface

// ==== core/rht_sensor_end.sv ====
// Sensor end of the two-wire bus port: target logic, busy timing.
// Assumes bus pins arrive from outside and are filtered here.
module rht_sensor_end #(
  parameter int T10MS_CYC      = rht_pkg::T10MS_CYC,
  parameter int SOFT_RESET_CYC = rht_pkg::SOFT_RESET_CYC,
  parameter int PIN_RESET_CYC  = rht_pkg::PIN_RESET_CYC,
  parameter int POWER_UP_CYC   = rht_pkg::POWER_UP_CYC
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Bus side
  rht_bus_if.dev           bus,
  // Measurement samples from the converter
  input  wire logic [15:0] temp_sample,
  input  wire logic [15:0] hum_sample,
  // Status
  output logic             busy,
  output logic             conv_active,
  output logic             heater_on,
  output logic [1:0]       humidity_oversampling,
  output logic [1:0]       temperature_oversampling
);
  typedef rht_pkg::rht_dev_state_type st_t;

  if (T10MS_CYC < 1 || SOFT_RESET_CYC < 1 || PIN_RESET_CYC < 1 ||
      POWER_UP_CYC < 1) begin : g_chk
    $error("rht_sensor_end: timing counts must be at least one");
  end

  function automatic logic [7:0] crc8(input logic [15:0] d);
    logic [7:0] c;
    c = rht_pkg::CRC_INIT;
    for (int i = 15; i >= 0; i--) begin
      if (c[7] ^ d[i]) begin
        c = {c[6:0], 1'b0} ^ rht_pkg::CRC_POLY;
      end else begin
        c = {c[6:0], 1'b0};
      end
    end
    return c;
  endfunction

  function automatic logic [31:0] conv_cyc(input logic [1:0] ho,
                                           input logic [1:0] to);
    int t;
    t = (rht_pkg::HUM_CONV_T10MS[ho] + rht_pkg::TEMP_CONV_T10MS[to]) *
        T10MS_CYC;
    return 32'(t);
  endfunction

  // Pin filter: bit 3 scl, 2 sda, 1 reset pin, 0 strap
  logic [3:0]  s1_reg, s2_reg, s3_reg, flt_reg, prv_reg;
  logic [3:0]  flt_next;
  st_t         st_reg, st_next;
  logic [3:0]  bcnt_reg, bcnt_next;
  logic [7:0]  sh_reg, sh_next;
  logic        rw_reg, rw_next;
  logic        ack_reg, ack_next;
  logic        strap_reg, strap_next;
  logic [47:0] tx_reg, tx_next;
  logic        oe_reg, oe_next;
  logic [31:0] bcyc_reg, bcyc_next;
  logic        conv_reg, conv_next;
  logic        heat_reg, heat_next;
  logic [1:0]  ho_reg, ho_next, to_reg, to_next;
  logic [15:0] t_reg, t_next, h_reg, h_next;
  logic        rise, fall, start, stop;
  logic [7:0]  cmd;

  always_comb begin
    // A change counts once the second and third stages agree
    flt_next = ((s2_reg ~^ s3_reg) & s2_reg) |
               (~(s2_reg ~^ s3_reg) & flt_reg);
    rise  = flt_reg[3] & ~prv_reg[3];
    fall  = ~flt_reg[3] & prv_reg[3];
    start = flt_reg[3] & prv_reg[3] & prv_reg[2] & ~flt_reg[2];
    stop  = flt_reg[3] & prv_reg[3] & ~prv_reg[2] & flt_reg[2];
    cmd   = sh_reg & rht_pkg::CMD_MASK;
    st_next    = st_reg;
    bcnt_next  = bcnt_reg;
    sh_next    = sh_reg;
    rw_next    = rw_reg;
    ack_next   = ack_reg;
    strap_next = strap_reg;
    tx_next    = tx_reg;
    oe_next    = oe_reg;
    bcyc_next  = bcyc_reg;
    conv_next  = conv_reg;
    heat_next  = heat_reg;
    ho_next    = ho_reg;
    to_next    = to_reg;
    t_next     = t_reg;
    h_next     = h_reg;
    if (bcyc_reg != 32'h0) begin
      bcyc_next = bcyc_reg - 32'h1;
      if (bcyc_reg == 32'h1 && conv_reg) begin
        conv_next = 1'b0;
        t_next    = temp_sample;
        h_next    = hum_sample;
      end
    end
    // No timeout anywhere: each state waits for the next bus edge
    case (st_reg)
      rht_pkg::DS_ADDR, rht_pkg::DS_CMD: begin
        if (rise) begin
          sh_next   = {sh_reg[6:0], flt_reg[2]};
          bcnt_next = bcnt_reg + 4'h1;
        end
        if (fall && bcnt_reg == 4'h8) begin
          bcnt_next = 4'h0;
          if (st_reg == rht_pkg::DS_CMD) begin
            st_next = rht_pkg::DS_CMD_AK;
            oe_next = 1'b1;
            if (sh_reg[7:rht_pkg::CONV_TOP_POS] == rht_pkg::CMD_CONV_TOP)
            begin
              ho_next   = sh_reg[rht_pkg::HUM_OSR_POS +: 2];
              to_next   = sh_reg[rht_pkg::TEMP_OSR_POS +: 2];
              conv_next = 1'b1;
              bcyc_next = conv_cyc(ho_next, to_next);
            end else if (cmd == rht_pkg::CMD_READ_TRH) begin
              tx_next = {t_reg, crc8(t_reg), h_reg, crc8(h_reg)};
            end else if (cmd == rht_pkg::CMD_READ_RH) begin
              tx_next = {h_reg, crc8(h_reg), 24'hffffff};
            end else if (cmd == rht_pkg::CMD_RESET) begin
              heat_next = 1'b0;
              ho_next   = 2'h0;
              to_next   = 2'h0;
              conv_next = 1'b0;
              bcyc_next = 32'(SOFT_RESET_CYC);
            end else if (cmd == rht_pkg::CMD_HEAT_ON) begin
              heat_next = 1'b1;
            end else if (cmd == rht_pkg::CMD_HEAT_OFF) begin
              heat_next = 1'b0;
            end
          end else if (sh_reg[7:1] == {rht_pkg::ADDR_BASE[6:1], strap_reg}
                       && bcyc_reg == 32'h0) begin
            st_next = rht_pkg::DS_ADDR_AK;
            oe_next = 1'b1;
            rw_next = sh_reg[0];
          end else begin
            st_next = rht_pkg::DS_IDLE;
          end
        end
      end
      rht_pkg::DS_ADDR_AK: begin
        if (fall) begin
          st_next = rw_reg ? rht_pkg::DS_TX : rht_pkg::DS_CMD;
          oe_next = rw_reg & ~tx_reg[47];
        end
      end
      rht_pkg::DS_CMD_AK: begin
        // One command byte per transaction; later bytes are ignored
        if (fall) begin
          st_next = rht_pkg::DS_IDLE;
          oe_next = 1'b0;
        end
      end
      rht_pkg::DS_TX: begin
        if (rise) begin
          bcnt_next = bcnt_reg + 4'h1;
        end
        if (fall) begin
          tx_next = {tx_reg[46:0], 1'b1};
          if (bcnt_reg == 4'h8) begin
            st_next   = rht_pkg::DS_TX_AK;
            bcnt_next = 4'h0;
            oe_next   = 1'b0;
          end else begin
            oe_next = ~tx_reg[46];
          end
        end
      end
      rht_pkg::DS_TX_AK: begin
        if (rise) begin
          ack_next = ~flt_reg[2];
        end
        if (fall) begin
          st_next = ack_reg ? rht_pkg::DS_TX : rht_pkg::DS_IDLE;
          oe_next = ack_reg & ~tx_reg[47];
        end
      end
      rht_pkg::DS_IDLE: begin
        oe_next = 1'b0;
      end
      default: begin
        st_next = rht_pkg::DS_IDLE;
        oe_next = 1'b0;
      end
    endcase
    if (start) begin
      st_next    = rht_pkg::DS_ADDR;
      bcnt_next  = 4'h0;
      oe_next    = 1'b0;
      strap_next = flt_reg[0];
    end
    if (stop) begin
      st_next = rht_pkg::DS_IDLE;
      oe_next = 1'b0;
    end
    // Reset pin held low keeps reloading the busy time
    if (!flt_reg[1]) begin
      st_next   = rht_pkg::DS_IDLE;
      oe_next   = 1'b0;
      heat_next = 1'b0;
      conv_next = 1'b0;
      ho_next   = 2'h0;
      to_next   = 2'h0;
      bcyc_next = 32'(PIN_RESET_CYC);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s1_reg    <= 4'hf;
      s2_reg    <= 4'hf;
      s3_reg    <= 4'hf;
      flt_reg   <= 4'hf;
      prv_reg   <= 4'hf;
      st_reg    <= rht_pkg::DS_IDLE;
      bcnt_reg  <= 4'h0;
      sh_reg    <= 8'h00;
      rw_reg    <= 1'b0;
      ack_reg   <= 1'b0;
      strap_reg <= 1'b0;
      tx_reg    <= 48'hffffffffffff;
      oe_reg    <= 1'b0;
      bcyc_reg  <= 32'(POWER_UP_CYC);
      conv_reg  <= 1'b0;
      heat_reg  <= 1'b0;
      ho_reg    <= 2'h0;
      to_reg    <= 2'h0;
      t_reg     <= 16'h0000;
      h_reg     <= 16'h0000;
    end else begin
      s1_reg    <= {bus.scl, bus.sda, bus.sensor_rst_n,
                    bus.address_select_pin};
      s2_reg    <= s1_reg;
      s3_reg    <= s2_reg;
      flt_reg   <= flt_next;
      prv_reg   <= flt_reg;
      st_reg    <= st_next;
      bcnt_reg  <= bcnt_next;
      sh_reg    <= sh_next;
      rw_reg    <= rw_next;
      ack_reg   <= ack_next;
      strap_reg <= strap_next;
      tx_reg    <= tx_next;
      oe_reg    <= oe_next;
      bcyc_reg  <= bcyc_next;
      conv_reg  <= conv_next;
      heat_reg  <= heat_next;
      ho_reg    <= ho_next;
      to_reg    <= to_next;
      t_reg     <= t_next;
      h_reg     <= h_next;
    end
  end

  // Open drain: the output level is always low, only the enable moves
  assign bus.dev_sda_o             = 1'b0;
  assign bus.dev_sda_oe            = oe_reg;
  assign busy                      = |bcyc_reg;
  assign conv_active               = conv_reg;
  assign heater_on                 = heat_reg;
  assign humidity_oversampling     = ho_reg;
  assign temperature_oversampling  = to_reg;
endmodule // rht_sensor_end

// ==== core/rht_host_end.sv ====
// Host end: bus controller that issues one command or one read.
// Assumes the sensor end on the far side of rht_bus_if.
module rht_host_end #(
  parameter int QTR_CYC        = rht_pkg::QTR_CYC,
  parameter int POWER_UP_CYC   = rht_pkg::POWER_UP_CYC,
  parameter int SOFT_RESET_CYC = rht_pkg::SOFT_RESET_CYC,
  parameter int PIN_RESET_CYC  = rht_pkg::PIN_RESET_CYC
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Bus side
  rht_bus_if.host          bus,
  // Request
  input  wire logic        req_valid,
  input  wire logic        req_read,
  input  wire logic [7:0]  req_byte,
  input  wire logic [2:0]  req_len,
  input  wire logic        req_lsb,
  input  wire logic        req_pin_reset,
  // Answer
  output logic             req_ready,
  output logic             done,
  output logic             nacked,
  output logic [47:0]      rd_data
);
  typedef rht_pkg::rht_host_state_type st_t;

  if (QTR_CYC < 8 || QTR_CYC > 65535 || POWER_UP_CYC < 1 ||
      SOFT_RESET_CYC < 1 || PIN_RESET_CYC < 1) begin : g_chk
    $error("rht_host_end: unsupported timing parameters");
  end

  st_t         st_reg, st_next;
  logic [15:0] q_reg, q_next;
  logic [1:0]  ph_reg, ph_next;
  logic [3:0]  k_reg, k_next;
  logic [2:0]  bi_reg, bi_next, nb_reg, nb_next;
  logic [7:0]  sh_reg, sh_next, cmd_reg, cmd_next;
  logic        rd_reg, rd_next, nk_reg, nk_next, asel_reg, asel_next;
  logic [47:0] dat_reg, dat_next;
  logic [31:0] w_reg, w_next;
  logic        scl_reg, scl_next, sda_reg, sda_next, prs_reg, prs_next;
  logic        rdy_reg, done_reg, done_next;
  logic        s1_reg, s2_reg, s3_reg, flt_reg;
  logic        tick, wr_byte;

  always_comb begin
    tick    = (q_reg == 16'(QTR_CYC - 1));
    wr_byte = (bi_reg == 3'h0) | ~rd_reg;
    st_next = st_reg;  q_next = 16'h0;  ph_next = ph_reg;
    k_next = k_reg;  bi_next = bi_reg;  nb_next = nb_reg;
    sh_next = sh_reg;  cmd_next = cmd_reg;  rd_next = rd_reg;
    nk_next = nk_reg;  asel_next = asel_reg;  dat_next = dat_reg;
    w_next = w_reg;  scl_next = scl_reg;  sda_next = sda_reg;
    prs_next = 1'b1;  done_next = 1'b0;
    if (st_reg == rht_pkg::HS_START || st_reg == rht_pkg::HS_BIT ||
        st_reg == rht_pkg::HS_STOP) begin
      q_next = tick ? 16'h0 : q_reg + 16'h1;
      if (tick) begin
        ph_next = ph_reg + 2'h1;
      end
    end
    case (st_reg)
      rht_pkg::HS_IDLE: begin
        if (req_pin_reset) begin
          st_next  = rht_pkg::HS_PRST;
          prs_next = 1'b0;
          w_next   = 32'(rht_pkg::RESET_PULSE_CYC - 1);
        end else if (req_valid) begin
          st_next   = rht_pkg::HS_START;
          ph_next   = 2'h0;
          rd_next   = req_read;
          cmd_next  = req_byte;
          nb_next   = req_read ? req_len + 3'h1 : 3'h2;
          asel_next = req_lsb;
          nk_next   = 1'b0;
          dat_next  = 48'h0;
        end
      end
      rht_pkg::HS_PRST: begin
        prs_next = 1'b0;
        w_next   = w_reg - 32'h1;
        if (w_reg == 32'h0) begin
          prs_next = 1'b1;
          st_next  = rht_pkg::HS_WAIT;
          w_next   = 32'(PIN_RESET_CYC);
        end
      end
      rht_pkg::HS_WAIT: begin
        w_next = w_reg - 32'h1;
        if (w_reg <= 32'h1) begin
          st_next = rht_pkg::HS_IDLE;
        end
      end
      rht_pkg::HS_START: begin
        if (tick && ph_reg == 2'h0) sda_next = 1'b1;
        if (tick && ph_reg == 2'h1) scl_next = 1'b1;
        if (tick && ph_reg == 2'h3) begin
          st_next = rht_pkg::HS_BIT;
          k_next  = 4'h0;
          bi_next = 3'h0;
          sh_next = {rht_pkg::ADDR_BASE[6:1], asel_reg, rd_reg};
        end
      end
      rht_pkg::HS_BIT: begin
        // Data moves only in the low phase right after a fall
        if (ph_reg == 2'h0 && q_reg == 16'h0) begin
          if (k_reg != 4'h8) sda_next = wr_byte & ~sh_reg[7];
          else sda_next = ~wr_byte & (bi_reg != nb_reg - 3'h1);
        end
        if (tick && ph_reg == 2'h0) scl_next = 1'b0;
        if (tick && ph_reg == 2'h2) begin
          if (k_reg != 4'h8 && !wr_byte) dat_next = {dat_reg[46:0], flt_reg};
          if (k_reg == 4'h8 && wr_byte && flt_reg) nk_next = 1'b1;
        end
        if (tick && ph_reg == 2'h3) begin
          scl_next = 1'b1;
          if (k_reg != 4'h8) begin
            k_next  = k_reg + 4'h1;
            sh_next = {sh_reg[6:0], 1'b0};
          end else begin
            k_next  = 4'h0;
            bi_next = bi_reg + 3'h1;
            sh_next = cmd_reg;
            if (nk_reg || bi_reg == nb_reg - 3'h1) st_next = rht_pkg::HS_STOP;
          end
        end
      end
      rht_pkg::HS_STOP: begin
        if (ph_reg == 2'h0 && q_reg == 16'h0) sda_next = 1'b1;
        if (tick && ph_reg == 2'h0) scl_next = 1'b0;
        if (tick && ph_reg == 2'h1) sda_next = 1'b0;
        if (tick && ph_reg == 2'h3) begin
          done_next = 1'b1;
          st_next   = rht_pkg::HS_IDLE;
          if (!rd_reg && !nk_reg &&
              (cmd_reg & rht_pkg::CMD_MASK) == rht_pkg::CMD_RESET) begin
            st_next = rht_pkg::HS_WAIT;
            w_next  = 32'(SOFT_RESET_CYC);
          end
        end
      end
      default: st_next = rht_pkg::HS_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_reg <= rht_pkg::HS_WAIT;  q_reg <= 16'h0;  ph_reg <= 2'h0;
      k_reg <= 4'h0;  bi_reg <= 3'h0;  nb_reg <= 3'h0;
      sh_reg <= 8'h00;  cmd_reg <= 8'h00;  rd_reg <= 1'b0;
      nk_reg <= 1'b0;  asel_reg <= 1'b0;  dat_reg <= 48'h0;
      w_reg <= 32'(POWER_UP_CYC);
      scl_reg <= 1'b0;  sda_reg <= 1'b0;  prs_reg <= 1'b1;
      rdy_reg <= 1'b0;  done_reg <= 1'b0;
      s1_reg <= 1'b1;  s2_reg <= 1'b1;  s3_reg <= 1'b1;  flt_reg <= 1'b1;
    end else begin
      st_reg <= st_next;  q_reg <= q_next;  ph_reg <= ph_next;
      k_reg <= k_next;  bi_reg <= bi_next;  nb_reg <= nb_next;
      sh_reg <= sh_next;  cmd_reg <= cmd_next;  rd_reg <= rd_next;
      nk_reg <= nk_next;  asel_reg <= asel_next;  dat_reg <= dat_next;
      w_reg <= w_next;  scl_reg <= scl_next;  sda_reg <= sda_next;
      prs_reg <= prs_next;  done_reg <= done_next;
      rdy_reg <= (st_next == rht_pkg::HS_IDLE);
      s1_reg <= bus.sda;  s2_reg <= s1_reg;  s3_reg <= s2_reg;
      flt_reg <= (s2_reg == s3_reg) ? s2_reg : flt_reg;
    end
  end

  assign bus.host_scl_o         = 1'b0;
  assign bus.host_scl_oe        = scl_reg;
  assign bus.host_sda_o         = 1'b0;
  assign bus.host_sda_oe        = sda_reg;
  assign bus.address_select_pin = asel_reg;
  assign bus.sensor_rst_n       = prs_reg;
  assign req_ready              = rdy_reg;
  assign done                   = done_reg;
  assign nacked                 = nk_reg;
  assign rd_data                = dat_reg;
endmodule // rht_host_end

// ==== verif/rht_bus_asserts.sv ====
// Wire-level checks between the host end and the sensor end.
// Assumes one clock domain and the interface signals passed by name.
module rht_bus_asserts #(
  parameter int RESET_PULSE_CYC = rht_pkg::RESET_PULSE_CYC
) (
  // Clock and reset
  input logic clk,
  input logic rst_n,
  // Resolved wires and enables
  input logic scl,
  input logic sda,
  input logic host_scl_oe,
  input logic host_sda_oe,
  input logic dev_sda_oe,
  // Side pins
  input logic sensor_rst_n,
  input logic address_select_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        scl_reg;
  logic        sda_reg;
  logic        in_txn_reg;
  logic [15:0] rst_low_reg;
  // Frames come from the raw wires, as any target on the bus sees them
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      scl_reg <= 1'b1;
      sda_reg <= 1'b1;
      in_txn_reg <= 1'b0;
      rst_low_reg <= 16'h0000;
    end else begin
      scl_reg <= scl;
      sda_reg <= sda;
      if (scl && scl_reg && (sda != sda_reg))
        in_txn_reg <= ~sda;
      rst_low_reg <= sensor_rst_n ? 16'h0000 : rst_low_reg + 16'h0001;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_start;
    scl && scl_reg && sda_reg && !sda;
  endsequence
  sequence s_quiet;
    !in_txn_reg && !$past(in_txn_reg);
  endsequence
  a_dev_edge_low: assert property ($changed(dev_sda_oe) |-> !scl)
    else $error("sensor data moved while clock high");
  a_dev_settled: assert property ($fell(scl) |-> ##12 $stable(dev_sda_oe) [*8])
    else $error("sensor data not steady after clock fall");
  a_host_data_low: assert property (scl && $changed(host_sda_oe) |-> host_sda_oe == !in_txn_reg)
    else $error("host data moved while clock high");
  a_strap_steady: assert property (in_txn_reg |-> $stable(address_select_pin))
    else $error("strap changed inside a transaction");
  a_rst_pulse_width: assert property ($rose(sensor_rst_n) |-> rst_low_reg >= RESET_PULSE_CYC)
    else $error("reset pin pulse too short");
  a_scl_idle_high: assert property (!in_txn_reg |-> !host_scl_oe)
    else $error("clock pulled outside a frame");
  a_start_clock: assert property (s_start |-> ##[1:64] !scl)
    else $error("no clock after start");
  a_dev_quiet: assert property (s_quiet |-> !dev_sda_oe)
    else $error("sensor drove data outside a frame");
endmodule // rht_bus_asserts

// ==== verif/tb_top.sv ====
// Bench joining host and sensor ends over the bus, with a bench model.
// Assumes shortened timing parameters; expectations scale with them.
`define CHK(a, b) begin \
  total_checks++; \
  if ((a) !== (b)) begin \
    mismatches++; \
    $display("wrong value t=%0t got %h exp %h", $time, a, b); \
  end \
end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int T10 = 16;
  // Shortened timing so the whole run stays small
  localparam int HOST_QTR  = 16;
  localparam int HOST_WAIT = 80;
  localparam int DEV_WAIT  = 50;
  logic        clk, rst_n, req_valid, req_read, req_lsb, req_pin_reset;
  logic [7:0]  req_byte;
  logic [2:0]  req_len;
  logic [15:0] temp_sample, hum_sample, seed, mt, mh;
  logic        req_ready, done, nacked, busy, conv_active, heater_on;
  logic [1:0]  humidity_oversampling, temperature_oversampling, ho, to;
  logic [47:0] rd_data, ex, msk;
  int          mismatches = 0;
  int          total_checks = 0;
  int          cyc = 0;
  int          k, e;
  rht_bus_if bus ();
  // Host waits longer than the sensor so filter latency cannot race
  rht_host_end #(.QTR_CYC(HOST_QTR), .POWER_UP_CYC(HOST_WAIT),
    .SOFT_RESET_CYC(HOST_WAIT),
    .PIN_RESET_CYC(HOST_WAIT)) u_rht_host_end (.clk(clk), .rst_n(rst_n),
    .bus(bus), .req_valid(req_valid), .req_read(req_read),
    .req_byte(req_byte), .req_len(req_len), .req_lsb(req_lsb),
    .req_pin_reset(req_pin_reset), .req_ready(req_ready), .done(done),
    .nacked(nacked), .rd_data(rd_data));
  rht_sensor_end #(.T10MS_CYC(T10), .SOFT_RESET_CYC(DEV_WAIT),
    .PIN_RESET_CYC(DEV_WAIT), .POWER_UP_CYC(DEV_WAIT))
    u_rht_sensor_end (.clk(clk),
    .rst_n(rst_n), .bus(bus), .temp_sample(temp_sample),
    .hum_sample(hum_sample), .busy(busy), .conv_active(conv_active),
    .heater_on(heater_on), .humidity_oversampling(humidity_oversampling),
    .temperature_oversampling(temperature_oversampling));
  rht_bus_asserts u_rht_bus_asserts (.clk(clk), .rst_n(rst_n),
    .scl(bus.scl), .sda(bus.sda), .host_scl_oe(bus.host_scl_oe),
    .host_sda_oe(bus.host_sda_oe), .dev_sda_oe(bus.dev_sda_oe),
    .sensor_rst_n(bus.sensor_rst_n),
    .address_select_pin(bus.address_select_pin));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [7:0] crc8(input logic [15:0] d);
    logic [7:0] c;
    c = rht_pkg::CRC_INIT;
    for (int j = 15; j >= 0; j--) begin
      c = (c[7] ^ d[j]) ? {c[6:0], 1'b0} ^ rht_pkg::CRC_POLY : {c[6:0], 1'b0};
    end
    return c;
  endfunction
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic wait_rdy();
    int n;
    n = 0;
    @(negedge clk);
    while (req_ready !== 1'b1 && n < 5000) begin
      @(negedge clk);
      n++;
    end
  endtask
  task automatic run(input logic rd, input logic [7:0] b,
                     input logic [2:0] n, input logic l);
    int w;
    wait_rdy();
    req_read = rd;
    req_byte = b;
    req_len = n;
    req_lsb = l;
    req_valid = 1'b1;
    @(negedge clk);
    req_valid = 1'b0;
    w = 0;
    while (done !== 1'b1 && w < 8000) begin
      @(posedge clk);
      #1;
      w++;
    end
  endtask
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 90000) begin
      mismatches++;
      results();
    end
  end
  initial begin
    {req_valid, req_read, req_lsb, req_pin_reset} = 4'h0;
    req_byte = 8'h00;
    req_len = 3'h0;
    temp_sample = 16'h0000;
    hum_sample = 16'h0000;
    seed = 16'hf5a6;
    rst_n = 1'b0;
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    wait_rdy();
    req_pin_reset = 1'b1;
    @(negedge clk);
    req_pin_reset = 1'b0;
    repeat (100) @(negedge clk);
    `CHK(bus.sensor_rst_n, 1'b0)
    repeat (170) @(negedge clk);
    `CHK(busy, 1'b1)
    for (int i = 0; i < 6; i++) begin
      ho = i[1:0];
      to = ~ho;
      @(negedge clk);
      seed = lfsr(seed);
      temp_sample = seed;
      mt = seed;
      seed = lfsr(seed);
      hum_sample = seed;
      mh = seed;
      run(1'b0, {rht_pkg::CMD_CONV_TOP, ho, to, 1'b0}, 3'h0, i[1]);
      `CHK(nacked, 1'b0)
      `CHK({humidity_oversampling, temperature_oversampling}, {ho, to})
      `CHK(conv_active, 1'b1)
      if (i == 0) begin
        run(1'b0, rht_pkg::CMD_READ_TRH, 3'h0, 1'b0);
        `CHK(nacked, 1'b1)
      end
      e = (rht_pkg::HUM_CONV_T10MS[ho] + rht_pkg::TEMP_CONV_T10MS[to]) * T10;
      k = 0;
      while (busy !== 1'b0 && k < 4000) begin
        @(posedge clk);
        k++;
      end
      `CHK(k <= e && k + 1800 >= e, 1'b1)
      run(1'b0, i[0] ? rht_pkg::CMD_READ_RH : rht_pkg::CMD_READ_TRH,
          3'h0, i[1]);
      `CHK(nacked, 1'b0)
      ex = i[0] ? {24'h0, mh, crc8(mh)} : {mt, crc8(mt), mh, crc8(mh)};
      msk = i[0] ? 48'h0000_00ff_ffff : 48'hffff_ffff_ffff;
      run(1'b1, 8'h00, i[0] ? 3'h3 : 3'h6, i[1]);
      `CHK(rd_data & msk, ex)
    end
    run(1'b0, rht_pkg::CMD_HEAT_ON, 3'h0, 1'b0);
    run(1'b0, rht_pkg::CMD_RESET, 3'h0, 1'b0);
    repeat (10) @(negedge clk);
    `CHK({heater_on, humidity_oversampling, temperature_oversampling}, 5'h00)
    run(1'b0, {rht_pkg::CMD_CONV_TOP, 4'h5, 1'b0}, 3'h0, 1'b1);
    `CHK(nacked, 1'b0)
    results();
  end
endmodule // tb_top
